// >>> verilog/mrd_decoder.sv
// sequencer, decoder and datapath for fourteen-bit instruction words
//
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "mrd_cfg.svh"

module mrd_decoder #(
    parameter logic [`MRD_FILE_W-1:0] TIMER_ZERO_ADDR = `MRD_TIMER_ZERO_ADDR
) (
    input  wire logic                   clk_in,
    input  wire logic                   reset_n_in,
    input  wire logic [`MRD_WORD_W-1:0] instr_in,
    input  wire logic [7:0]             acc_in,
    input  wire logic [7:0]             file_rd_in,
    input  wire logic                   carry_in,
    input  wire logic                   prescaler_to_timer_in,
    output logic                        fetch_out,
    output logic [1:0]                  phase_out,
    output logic                        nop_cycle_out,
    output logic [`MRD_FILE_W-1:0]      file_addr_out,
    output mrd_pkg::mrd_commit_t        commit_out,
    output logic                        watchdog_expired_flag_out,
    output logic                        power_down_flag_out
);
    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    function automatic mrd_pkg::mrd_ctl_t decode(input logic [`MRD_WORD_W-1:0] w);
        mrd_pkg::mrd_ctl_t c;
        logic              d;
        c = '0;
        d = w[`MRD_DEST_POS];
        case (w[`MRD_CLS_HI:`MRD_CLS_LO])
            `MRD_CLS_BYTE: begin
                c.wr_file = d;
                c.wr_acc  = !d;
                c.upd_z   = 1'b1;
                case (w[`MRD_NIB_HI:`MRD_NIB_LO])
                    4'h0: begin
                        c.upd_z   = 1'b0;
                        c.wr_acc  = 1'b0;
                        c.alu     = mrd_pkg::ALU_PASSW;
                        // bits 7..0 of the no-op form are decoded: 08 and 09 pop, 63 standby, 64 kick
                        // d must be zero too, else a move-w-to-file would alias
                        case (w[7:0])
                            8'h08:   c.pop = 1'b1;
                            8'h09:   c.pop = 1'b1;
                            8'h63:   c.standby = 1'b1;
                            8'h64:   c.kick = 1'b1;
                            default: c.pop = 1'b0;
                        endcase
                    end
                    4'h1: c.alu = mrd_pkg::ALU_ZERO;
                    4'h2: c.alu = mrd_pkg::ALU_SUB;
                    4'h3: c.alu = mrd_pkg::ALU_DEC;
                    4'h4: c.alu = mrd_pkg::ALU_OR;
                    4'h5: c.alu = mrd_pkg::ALU_AND;
                    4'h6: c.alu = mrd_pkg::ALU_XOR;
                    4'h7: c.alu = mrd_pkg::ALU_ADD;
                    4'h8: c.alu = mrd_pkg::ALU_PASSB;
                    4'h9: c.alu = mrd_pkg::ALU_COM;
                    4'hA: c.alu = mrd_pkg::ALU_INC;
                    4'hB: c.alu = mrd_pkg::ALU_DEC;
                    4'hC: c.alu = mrd_pkg::ALU_RR;
                    4'hD: c.alu = mrd_pkg::ALU_RL;
                    4'hE: c.alu = mrd_pkg::ALU_SWAP;
                    default: c.alu = mrd_pkg::ALU_INC;
                endcase
                if (w[11:8] == 4'hB || w[11:8] == 4'hF) begin
                    c.skip_z = 1'b1;
                    c.upd_z  = 1'b0;
                end
                if (w[11:8] == 4'hC || w[11:8] == 4'hD || w[11:8] == 4'hE) begin
                    c.upd_z = 1'b0;
                end
                c.upd_c  = (w[11:8] == 4'h2) || (w[11:8] == 4'h7)
                           || (w[11:8] == 4'hC) || (w[11:8] == 4'hD);
                c.upd_dc = (w[11:8] == 4'h2) || (w[11:8] == 4'h7);
                if (w[11:8] == 4'h0 && d) begin
                    c.wr_file = 1'b1;
                end
                if (w[11:8] == 4'h1 && !d) begin
                    c.wr_acc = 1'b1; // clear of w ignores bits 6..0
                end
            end
            `MRD_CLS_BIT: begin
                c.alu      = (w[10]) ? mrd_pkg::ALU_BSET : mrd_pkg::ALU_BCLR;
                c.wr_file  = !w[11];
                c.skip_clr = (w[11:10] == 2'h2);
                c.skip_set = (w[11:10] == 2'h3);
            end
            `MRD_CLS_JUMP: begin
                c.jump = 1'b1;
                c.push = !w[11];
            end
            default: begin
                c.src_lit = 1'b1;
                c.wr_acc  = 1'b1;
                c.alu     = mrd_pkg::ALU_PASSB;
                casez (w[11:8])
                    4'b00??: c.alu = mrd_pkg::ALU_PASSB;
                    4'b01??: c.pop = 1'b1;
                    4'b1000: c.alu = mrd_pkg::ALU_OR;
                    4'b1001: c.alu = mrd_pkg::ALU_AND;
                    4'b1010: c.alu = mrd_pkg::ALU_XOR;
                    4'b110?: c.alu = mrd_pkg::ALU_SUB;
                    default: c.alu = mrd_pkg::ALU_ADD;
                endcase
                c.upd_z  = w[11];
                c.upd_c  = (w[11:10] == 2'h3);
                c.upd_dc = (w[11:10] == 2'h3);
            end
        endcase
        return c;
    endfunction

    // ------------------------------------------------------------
    // sequencer state
    // ------------------------------------------------------------
    mrd_pkg::mrd_phase_t    phase_r, phase_nxt;
    logic [`MRD_WORD_W-1:0] ir_r, ir_nxt;
    logic                   take2_r, take2_nxt;
    logic                   nop_cyc_r, nop_cyc_nxt;
    mrd_pkg::mrd_commit_t   commit_r, commit_nxt;
    logic                   to_r, to_nxt;
    logic                   pd_r, pd_nxt;
    mrd_pkg::mrd_ctl_t      ctl;
    logic [7:0]             opb;
    logic [7:0]             res;
    logic [7:0]             mask;
    logic                   c_res;
    logic                   dc_res;
    logic                   bit_val;
    logic                   skip;
    logic [8:0]             sum9;
    logic [4:0]             sum5;

    // operand fields of the word being executed
    assign ctl           = decode(ir_r);
    assign file_addr_out = ir_r[`MRD_FILE_W-1:0];
    assign mask          = 8'h01 << ir_r[`MRD_BIT_HI:`MRD_BIT_LO];
    assign opb           = ctl.src_lit ? ir_r[`MRD_LIT8_HI:0] : file_rd_in;

    // ------------------------------------------------------------
    // datapath
    // ------------------------------------------------------------
    always_comb begin
        res    = 8'h00;
        c_res  = carry_in;
        sum9   = 9'h000;
        sum5   = 5'h00;
        case (ctl.alu)
            mrd_pkg::ALU_PASSW: res = acc_in;
            mrd_pkg::ALU_PASSB: res = opb;
            mrd_pkg::ALU_ZERO:  res = 8'h00;
            mrd_pkg::ALU_ADD: begin
                sum9 = {1'b0, opb} + {1'b0, acc_in};
                sum5 = {1'b0, opb[3:0]} + {1'b0, acc_in[3:0]};
            end
            mrd_pkg::ALU_SUB: begin // operand minus w, carry means no borrow
                sum9 = {1'b0, opb} + {1'b0, ~acc_in} + 9'h001;
                sum5 = {1'b0, opb[3:0]} + {1'b0, ~acc_in[3:0]} + 5'h01;
            end
            mrd_pkg::ALU_AND:  res = opb & acc_in;
            mrd_pkg::ALU_OR:   res = opb | acc_in;
            mrd_pkg::ALU_XOR:  res = opb ^ acc_in;
            mrd_pkg::ALU_COM:  res = ~opb;
            mrd_pkg::ALU_DEC:  res = opb - 8'h01;
            mrd_pkg::ALU_INC:  res = opb + 8'h01;
            mrd_pkg::ALU_RL: begin
                res   = {opb[6:0], carry_in};
                c_res = opb[7];
            end
            mrd_pkg::ALU_RR: begin
                res   = {carry_in, opb[7:1]};
                c_res = opb[0];
            end
            mrd_pkg::ALU_SWAP: res = {opb[3:0], opb[7:4]};
            mrd_pkg::ALU_BCLR: res = opb & ~mask;
            default:           res = opb | mask;
        endcase
        if (ctl.alu == mrd_pkg::ALU_ADD || ctl.alu == mrd_pkg::ALU_SUB) begin
            res   = sum9[7:0];
            c_res = sum9[8];
        end
    end

    assign dc_res  = sum5[4];
    assign bit_val = |(opb & mask);
    assign skip    = (ctl.skip_z && res == 8'h00) || (ctl.skip_set && bit_val)
                     || (ctl.skip_clr && !bit_val);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        phase_nxt   = mrd_pkg::mrd_phase_t'(phase_r + 2'h1);
        ir_nxt      = ir_r;
        take2_nxt   = take2_r;
        nop_cyc_nxt = nop_cyc_r;
        commit_nxt  = '0;
        to_nxt      = to_r;
        pd_nxt      = pd_r;
        if (phase_r == mrd_pkg::PH_Q3 && !nop_cyc_r) begin
            commit_nxt.result        = res;
            commit_nxt.acc_we        = ctl.wr_acc;
            commit_nxt.file_we       = ctl.wr_file;
            commit_nxt.z_we          = ctl.upd_z;
            commit_nxt.z             = (res == 8'h00);
            commit_nxt.c_we          = ctl.upd_c;
            commit_nxt.c             = c_res;
            commit_nxt.dc_we         = ctl.upd_dc;
            commit_nxt.dc            = dc_res;
            commit_nxt.pc_load       = ctl.jump;
            commit_nxt.pc_target     = ir_r[`MRD_LIT11_HI:0];
            commit_nxt.push          = ctl.push;
            commit_nxt.pop           = ctl.pop;
            commit_nxt.prescaler_clr = ctl.wr_file && prescaler_to_timer_in
                                       && file_addr_out == TIMER_ZERO_ADDR;
            commit_nxt.standby       = ctl.standby;
            commit_nxt.kick          = ctl.kick;
            take2_nxt                = ctl.jump || ctl.pop || skip;
        end
        if (phase_r == mrd_pkg::PH_Q4) begin
            ir_nxt      = take2_r ? `MRD_NOP_WORD : instr_in;
            nop_cyc_nxt = take2_r;
            take2_nxt   = 1'b0;
        end
        if (commit_r.kick) begin
            to_nxt = 1'b1;
            pd_nxt = 1'b1;
        end
        if (commit_r.standby) begin
            to_nxt = 1'b1;
            pd_nxt = 1'b0;
        end
    end

    // state registers
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            phase_r   <= mrd_pkg::PH_Q1;
            ir_r      <= `MRD_NOP_WORD;
            take2_r   <= 1'b0;
            nop_cyc_r <= 1'b0;
            commit_r  <= '0;
            to_r      <= `MRD_TO_RST;
            pd_r      <= `MRD_PD_RST;
        end else begin
            phase_r   <= phase_nxt;
            ir_r      <= ir_nxt;
            take2_r   <= take2_nxt;
            nop_cyc_r <= nop_cyc_nxt;
            commit_r  <= commit_nxt;
            to_r      <= to_nxt;
            pd_r      <= pd_nxt;
        end
    end

    // outputs
    assign fetch_out                 = (phase_r == mrd_pkg::PH_Q4) && !take2_r;
    assign phase_out                 = phase_r;
    assign nop_cycle_out             = nop_cyc_r;
    assign commit_out                = commit_r;
    assign watchdog_expired_flag_out = to_r;
    assign power_down_flag_out       = pd_r;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    sequence s_fetch_gap;
        !fetch_out [*3];
    endsequence
    sequence s_nop_cycle;
        nop_cyc_r ##3 (phase_r == mrd_pkg::PH_Q4 && commit_r == '0);
    endsequence

    property p_phase_wrap;
        phase_r == mrd_pkg::PH_Q4 |=> phase_r == mrd_pkg::PH_Q1;
    endproperty
    a_phase_wrap: assert property (p_phase_wrap) else $error("phase did not wrap");

    property p_fetch_gap;
        fetch_out |=> s_fetch_gap;
    endproperty
    a_fetch_gap: assert property (p_fetch_gap) else $error("fetch closer than four clocks");

    property p_commit_q4;
        (commit_r.acc_we || commit_r.file_we) |-> phase_r == mrd_pkg::PH_Q4 && !nop_cyc_r;
    endproperty
    a_commit_q4: assert property (p_commit_q4) else $error("commit outside last period");

    property p_pc_nop;
        commit_r.pc_load |=> s_nop_cycle;
    endproperty
    a_pc_nop: assert property (p_pc_nop) else $error("pc change without nop cycle");

    property p_dest;
        commit_r.file_we && ir_r[13:12] == 2'h0 && ir_r[11:8] != 4'h0 |-> ir_r[7];
    endproperty
    a_dest: assert property (p_dest) else $error("file written with destination zero");

    property p_bit_clear;
        commit_r.file_we && ir_r[13:10] == 4'h4 |-> (commit_r.result & mask) == 8'h00;
    endproperty
    a_bit_clear: assert property (p_bit_clear) else $error("selected bit not cleared");

    property p_logic_flags;
        phase_r == mrd_pkg::PH_Q4 && ir_r[13:12] == 2'h0 && ir_r[11:10] == 2'h1
        && ir_r[9:8] != 2'h3 |-> !commit_r.c_we && !commit_r.dc_we;
    endproperty
    a_logic_flags: assert property (p_logic_flags) else $error("logic op touched carry");

    property p_skip_zero;
        phase_r == mrd_pkg::PH_Q4 && !nop_cyc_r && ir_r[13:12] == 2'h0
        && ir_r[10:8] == 3'h3 && ir_r[11] && commit_r.result == 8'h00 |=> s_nop_cycle;
    endproperty
    a_skip_zero: assert property (p_skip_zero) else $error("zero result did not skip");

    property p_standby;
        commit_r.standby |=> !power_down_flag_out && watchdog_expired_flag_out;
    endproperty
    a_standby: assert property (p_standby) else $error("standby flags wrong");

    property p_prescaler;
        commit_r.prescaler_clr |-> commit_r.file_we;
    endproperty
    a_prescaler: assert property (p_prescaler) else $error("prescaler cleared without write");
endmodule // mrd_decoder
`default_nettype wire

// >>> verilog/mrd_cfg.svh
// constants for the mid-range instruction decoder
`ifndef MRD_CFG_SVH
`define MRD_CFG_SVH
`define MRD_WORD_W      14
`define MRD_FILE_W      7
`define MRD_CLS_HI      13
`define MRD_CLS_LO      12
`define MRD_NIB_HI      11
`define MRD_NIB_LO      8
`define MRD_DEST_POS    7
`define MRD_BIT_HI      9
`define MRD_BIT_LO      7
`define MRD_LIT8_HI     7
`define MRD_LIT11_HI    10
`define MRD_CLS_BYTE    2'h0
`define MRD_CLS_BIT     2'h1
`define MRD_CLS_JUMP    2'h2
`define MRD_CLS_LIT     2'h3
`define MRD_NOP_WORD    14'h0000
`define MRD_PHASES      4
`define MRD_TO_RST      1'h1
`define MRD_PD_RST      1'h1
`define MRD_TIMER_ZERO_ADDR   7'h01
`endif

// >>> verilog/mrd_pkg.sv
// types shared by the mid-range instruction decoder
`default_nettype none
package mrd_pkg;
    // oscillator period within one instruction cycle
    typedef enum logic [1:0] {
        PH_Q1 = 2'b00,
        PH_Q2 = 2'b01,
        PH_Q3 = 2'b10,
        PH_Q4 = 2'b11
    } mrd_phase_t;

    // datapath function
    typedef enum logic [3:0] {
        ALU_PASSW = 4'b0000,
        ALU_PASSB = 4'b0001,
        ALU_ZERO  = 4'b0010,
        ALU_ADD   = 4'b0011,
        ALU_SUB   = 4'b0100,
        ALU_AND   = 4'b0101,
        ALU_OR    = 4'b0110,
        ALU_XOR   = 4'b0111,
        ALU_COM   = 4'b1000,
        ALU_DEC   = 4'b1001,
        ALU_INC   = 4'b1010,
        ALU_RL    = 4'b1011,
        ALU_RR    = 4'b1100,
        ALU_SWAP  = 4'b1101,
        ALU_BCLR  = 4'b1110,
        ALU_BSET  = 4'b1111
    } mrd_alu_t;

    // decoded control word
    typedef struct packed {
        mrd_alu_t alu;
        logic     src_lit;
        logic     wr_acc;
        logic     wr_file;
        logic     upd_z;
        logic     upd_c;
        logic     upd_dc;
        logic     skip_z;
        logic     skip_set;
        logic     skip_clr;
        logic     jump;
        logic     push;
        logic     pop;
        logic     standby;
        logic     kick;
    } mrd_ctl_t;

    // one-clock commit bundle toward working register, files and pc
    typedef struct packed {
        logic [7:0]  result;
        logic        acc_we;
        logic        file_we;
        logic        z_we;
        logic        z;
        logic        c_we;
        logic        c;
        logic        dc_we;
        logic        dc;
        logic        pc_load;
        logic [10:0] pc_target;
        logic        push;
        logic        pop;
        logic        prescaler_clr;
        logic        standby;
        logic        kick;
    } mrd_commit_t;
endpackage
`default_nettype wire

// >>> sim/mrd_prog_mem.sv
// program memory stand-in that feeds fourteen-bit words to the decoder
`timescale 1ns/1ps
`default_nettype none
module mrd_prog_mem (
    input  wire logic [13:0] word_in,
    input  wire logic [1:0]  phase_in,
    input  wire logic        fetch_in,
    output logic      [13:0] instr_out,
    output logic             taken_out
);
    // word valid only in q4; inverted outside so a late sample shows
    assign instr_out = (phase_in == 2'h3) ? word_in : ~word_in;
    // a word leaves memory only when the decoder fetches it
    assign taken_out = (phase_in == 2'h3) && fetch_in;
endmodule // mrd_prog_mem
`default_nettype wire

// >>> sim/mid_range_instruction_decoder_tb.sv
// self-checking bench for the fourteen-bit instruction decoder
`timescale 1ns/1ps
`default_nettype none
module mid_range_instruction_decoder_tb;
    localparam logic [13:0]          nop_w = 14'h0000;
    localparam logic [13:0]          vic_w = 14'h38FF;
    localparam mrd_pkg::mrd_commit_t am    = '1;
    logic                 clk_in;
    logic                 reset_n_in;
    logic [13:0]          word;
    logic [13:0]          instr;
    logic [7:0]           acc;
    logic [7:0]           file;
    logic                 carry;
    logic                 psa;
    logic                 fetch;
    logic                 taken;
    logic [1:0]           phase;
    logic                 nop_cyc;
    logic [6:0]           faddr;
    mrd_pkg::mrd_commit_t commit;
    mrd_pkg::mrd_commit_t e;
    mrd_pkg::mrd_commit_t m;
    logic                 to_flag;
    logic                 pd_flag;
    int                   num_errors;
    int                   num_checks;

    mrd_decoder dut_u (
        .clk_in(clk_in), .reset_n_in(reset_n_in), .instr_in(instr), .acc_in(acc),
        .file_rd_in(file), .carry_in(carry), .prescaler_to_timer_in(psa),
        .fetch_out(fetch), .phase_out(phase), .nop_cycle_out(nop_cyc),
        .file_addr_out(faddr), .commit_out(commit),
        .watchdog_expired_flag_out(to_flag), .power_down_flag_out(pd_flag)
    );
    mrd_prog_mem mem_u (
        .word_in(word), .phase_in(phase), .fetch_in(fetch),
        .instr_out(instr), .taken_out(taken)
    );

    // free-running 100 MHz clock
    always #5 clk_in = ~clk_in;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // expected commit; fl = acc_we file_we z_we z c_we c dc_we dc
    function automatic mrd_pkg::mrd_commit_t mk(input logic [7:0] r, input logic [7:0] fl);
        mrd_pkg::mrd_commit_t x;
        x = '0;
        x.result = r;
        {x.acc_we, x.file_we, x.z_we, x.z, x.c_we, x.c, x.dc_we, x.dc} = fl;
        return x;
    endfunction

    // byte word on the top file address
    function automatic logic [13:0] bw(input logic [3:0] n, input logic d);
        return {2'h0, n, d, 7'h7F};
    endfunction

    // run one word (v follows it), judge its commit and the no-op cycles after it
    task automatic t(input logic [13:0] w, input logic [13:0] v, input logic [15:0] af,
                     input logic [1:0] cp, input mrd_pkg::mrd_commit_t ex,
                     input mrd_pkg::mrd_commit_t mask, input int n);
        mrd_pkg::mrd_commit_t g;
        int                   i;
        int                   k;
        logic [6:0]           fa;
        g = '0;
        k = 0;
        i = 0;
        fa = 7'h00;
        // commit always carries word bits 10..0 as the target
        if (!ex.pc_load) begin
            ex.pc_target = w[10:0];
        end
        word <= w;
        while (taken !== 1'b1 && i < 40) begin
            @(negedge clk_in);
            i++;
        end
        @(posedge clk_in);
        word <= v;
        acc <= af[15:8];
        file <= af[7:0];
        carry <= cp[1];
        psa <= cp[0];
        repeat (16) begin
            @(posedge clk_in);
            #1;
            if (phase === 2'h3 && g === '0) begin
                g  = commit;
                fa = faddr;
            end
            if (nop_cyc === 1'b1) k++;
        end
        word <= nop_w;
        repeat (12) @(posedge clk_in);
        #1;
        check(g & mask, ex & mask);
        check(33'(k), 33'(n));
        check(33'(fa), 33'(w[6:0]));
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic sc_reset;
        int k;
        repeat (12) @(posedge clk_in);
        #1;
        check(33'(phase), 33'h0);
        check(commit, 33'h0);
        check(33'({to_flag, pd_flag, fetch, nop_cyc}), 33'hC);
        @(posedge clk_in);
        reset_n_in <= 1'b1;
        for (k = 1; k <= 4; k++) begin
            @(posedge clk_in);
            #1;
            check(33'({fetch, phase}), 33'({k == 3, 2'(k)}));
        end
    endtask

    task automatic sc_byte;
        t(bw(4'h5, 1'h0), vic_w, 16'h3C0F, 2'h0, mk(8'h0C, 8'hA0), am, 0);
        t(bw(4'h5, 1'h0), vic_w, 16'h3CC3, 2'h0, mk(8'h00, 8'hB0), am, 0);
        t(bw(4'h4, 1'h1), vic_w, 16'h3C0F, 2'h0, mk(8'h3F, 8'h60), am, 0);
        t(bw(4'h6, 1'h0), vic_w, 16'h3C0F, 2'h0, mk(8'h33, 8'hA0), am, 0);
        t(bw(4'h7, 1'h1), vic_w, 16'h3C0F, 2'h0, mk(8'h4B, 8'h6B), am, 0);
        t(bw(4'h2, 1'h0), vic_w, 16'h3C0F, 2'h0, mk(8'hD3, 8'hAB), am, 0);
        t(bw(4'h1, 1'h1), vic_w, 16'h3C0F, 2'h0, mk(8'h00, 8'h70), am, 0);
        t(14'h0100, vic_w, 16'h3C0F, 2'h0, mk(8'h00, 8'hB0), am, 0);
        t(14'h017F, vic_w, 16'h3C0F, 2'h0, mk(8'h00, 8'hB0), am, 0);
    endtask

    task automatic sc_skip_rotate;
        t(bw(4'hB, 1'h1), vic_w, 16'h3C01, 2'h0, mk(8'h00, 8'h50), am, 4);
        t(bw(4'hF, 1'h0), vic_w, 16'h3C05, 2'h0, mk(8'h06, 8'h80), am, 0);
        t(bw(4'hF, 1'h1), vic_w, 16'h3CFF, 2'h0, mk(8'h00, 8'h50), am, 4);
        t(bw(4'hD, 1'h1), vic_w, 16'h3C81, 2'h0, mk(8'h02, 8'h4C), am, 0);
        t(bw(4'hC, 1'h0), vic_w, 16'h3C01, 2'h2, mk(8'h80, 8'h8C), am, 0);
    endtask

    task automatic sc_bits;
        m = mk(8'h00, 8'hEA);
        t(14'h13FF, vic_w, 16'h00FF, 2'h0, mk(8'h7F, 8'h40), am, 0);
        t(14'h147F, vic_w, 16'h0000, 2'h0, mk(8'h01, 8'h40), am, 0);
        t(14'h1DFF, nop_w, 16'h0008, 2'h0, '0, m, 4);
        t(14'h1DFF, nop_w, 16'h00F7, 2'h0, '0, m, 0);
        t(14'h19FF, nop_w, 16'h00F7, 2'h0, '0, m, 4);
        t(14'h19FF, nop_w, 16'h0008, 2'h0, '0, m, 0);
    endtask

    task automatic sc_literal;
        t(14'h380F, vic_w, 16'h3C00, 2'h0, mk(8'h3F, 8'hA0), am, 0);
        t(14'h390F, vic_w, 16'h3C00, 2'h0, mk(8'h0C, 8'hA0), am, 0);
        t(14'h3A0F, vic_w, 16'h3C00, 2'h0, mk(8'h33, 8'hA0), am, 0);
        t(14'h3E0F, vic_w, 16'h3C00, 2'h0, mk(8'h4B, 8'hAB), am, 0);
        t(14'h3F0F, vic_w, 16'h3C00, 2'h0, mk(8'h4B, 8'hAB), am, 0);
        t(14'h3E10, vic_w, 16'hF000, 2'h0, mk(8'h00, 8'hBE), am, 0);
        t(14'h3C0F, vic_w, 16'h3C00, 2'h0, mk(8'hD3, 8'hAB), am, 0);
        e = mk(8'h0F, 8'h80);
        e.pop = 1'b1;
        t(14'h340F, vic_w, 16'h3C00, 2'h0, e, am, 4);
    endtask

    task automatic sc_control;
        e = '0;
        e.push = 1'b1;
        e.pc_load = 1'b1;
        e.pc_target = 11'h5A5;
        m = mk(8'h00, 8'hC0);
        m.push = 1'b1;
        m.pc_load = 1'b1;
        m.pc_target = 11'h7FF;
        t(14'h25A5, vic_w, 16'h3C00, 2'h0, e, m, 4);
        e.push = 1'b0;
        e.pc_target = 11'h7FF;
        t(14'h2FFF, vic_w, 16'h3C00, 2'h0, e, m, 4);
    endtask

    task automatic sc_power_timer;
        m = mk(8'h00, 8'hC0);
        m.standby = 1'b1;
        m.kick = 1'b1;
        e = '0;
        e.standby = 1'b1;
        t(14'h0063, vic_w, 16'h3C00, 2'h0, e, m, 0);
        check(33'({to_flag, pd_flag}), 33'h2);
        e = '0;
        e.kick = 1'b1;
        t(14'h0064, vic_w, 16'h3C00, 2'h0, e, m, 0);
        check(33'({to_flag, pd_flag}), 33'h3);
        t(14'h00E3, vic_w, 16'h3C00, 2'h0, mk(8'h3C, 8'h40), am, 0);
        check(33'({to_flag, pd_flag}), 33'h3);
        m = '0;
        m.prescaler_clr = 1'b1;
        t(14'h0581, nop_w, 16'h3C0F, 2'h1, m, m, 0);
        t(14'h0501, nop_w, 16'h3C0F, 2'h1, '0, m, 0);
        t(14'h0581, nop_w, 16'h3C0F, 2'h0, '0, m, 0);
        t(14'h1401, nop_w, 16'h3C00, 2'h1, m, m, 0);
    endtask

    // main sequence
    initial begin
        clk_in = 1'b0;
        reset_n_in = 1'b0;
        word = nop_w;
        acc = 8'h00;
        file = 8'h00;
        carry = 1'b0;
        psa = 1'b0;
        num_errors = 0;
        num_checks = 0;
        sc_reset;
        sc_byte;
        sc_skip_rotate;
        sc_bits;
        sc_literal;
        sc_control;
        sc_power_timer;
        final_report;
    end

    // cut a hung run short
    initial begin
        #100000;
        num_errors++;
        final_report;
    end
endmodule // mid_range_instruction_decoder_tb
`default_nettype wire
